// ### rtm_pkg.sv
// shared constants, register map and state type of the reload timer bank
`default_nettype none

package rtm_pkg;

    // structure of the bank
    localparam int NUM_TMR = 4;
    localparam int CNT_W = 16;
    localparam int PRESCALE_SELECT_W = 12;
    localparam int ADDR_W = 8;

    // per-timer register offsets, timer n sits at n * TMR_STRIDE
    localparam logic [7:0] TMR_STRIDE = 8'h10;
    localparam logic [3:0] OFS_CTL = 4'h0;
    localparam logic [3:0] OFS_CNT = 4'h4;
    localparam logic [3:0] OFS_CMP = 4'h8;

    // bank-wide registers
    localparam logic [7:0] OFS_INT_STAT = 8'h40;
    localparam logic [7:0] OFS_INT_MASK = 8'h44;
    localparam logic [7:0] OFS_PIN_STAT = 8'h48;

    // timer_control_reg field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int CTL_POL_BIT = 4;
    localparam int CTL_OEN_BIT = 5;
    localparam int CTL_PRESCALE_SELECT_LSB = 16;

    // pin status field positions
    localparam int PIN_OUT_LSB = 0;
    localparam int PIN_IN_LSB = 8;

    // operating_mode_field encodings
    localparam logic [2:0] MODE_ONESHOT = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;

    // reset and reload values
    localparam logic [15:0] CNT_RELOAD = 16'h0001;
    localparam logic [15:0] CNT_RST = 16'h0001;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [11:0] PRESCALE_SELECT_RST = 12'h000;

    // whole state of the bank, one packed word
    typedef struct packed {
        logic [3:0] en;
        logic [3:0][2:0] mode;
        logic [3:0] pol;
        logic [3:0] oen;
        logic [3:0][11:0] prescale_select;
        logic [3:0][15:0] cnt;
        logic [3:0][15:0] cmp;
        logic [3:0] out;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [31:0] rdata;
    } rtm_state_t;

endpackage

`default_nettype wire

// ### rtm_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none

module rtm_sync3 #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // asynchronous level in, filtered level out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } rtm_sync_t;

    rtm_sync_t st_r;
    rtm_sync_t st_nxt;

    // s1 feeds only s2; the level moves only where s2 and s3 agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.lvl;

endmodule // rtm_sync3

`default_nettype wire

// ### rtm_prescaler.sv
// prescaler: one tick every (ratio_m1 + 1) cycles while run is high
`default_nettype none

module rtm_prescaler #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [W-1:0] ratio_m1,
    // one-cycle count enable
    output logic tick
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } rtm_prescale_select_t;

    rtm_prescale_select_t st_r;
    rtm_prescale_select_t st_nxt;

    // restarting from zero whenever run drops keeps the first period whole
    always_comb begin
        st_nxt = st_r;
        if (!run || tick) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = run && (st_r.cnt == ratio_m1);

endmodule // rtm_prescaler

`default_nettype wire

// ### rtm_timer_bank.sv
// bank of four reloadable 16-bit up-counting timers with register port
//
// How it works
// - each timer has a 16-bit counter that only counts up.
// - prescale ratio is programmable from 1 to 4096 clocks per count.
// - past FFFFh with no match the counter wraps to 0000h and goes on.
// - reload 0000h with prescale 4096 gives the longest timeout via a wrap.
// - mode 000 selects one-shot, counting from current value toward reload.
// - one-shot match raises the interrupt and loads 0001h into the count.
// - after a one-shot match the timer clears its enable and stops.
// - mode 001 selects continuous, repeatedly running up to the reload value.
// - continuous match raises the interrupt, holds the reload value, loads 0001h on the next step.
// - a written start count only affects the first continuous pass.
// - in both modes the count source is clk_sys through the prescaler.
// - one-shot timeout is (reload - start) times prescale in clk_sys cycles.
// - the output pin starts at the polarity bit when the timer is enabled.
// - four independent timer instances sit on the register port.
// - with output enabled the pin inverts on every reload match.
`default_nettype none

module rtm_timer_bank (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // timer pins
    input wire logic [3:0] tmr_in,
    output logic [3:0] tmr_out,
    output logic [3:0] tmr_out_oe,
    // interrupt
    output logic irq
);

    rtm_pkg::rtm_state_t s_r;
    rtm_pkg::rtm_state_t s_nxt;

    logic [3:0] tick;
    logic [3:0] run;
    logic [3:0] in_lvl;

    // only the two covered modes advance the counter; others hold
    function automatic logic mode_runs(input logic [2:0] m);
        mode_runs = (m == rtm_pkg::MODE_ONESHOT) || (m == rtm_pkg::MODE_CONT);
    endfunction

    // one prescaled step: a count sitting on the reload value goes back to 0001h,
    // any other count goes up by one and wraps FFFFh to 0000h by itself
    function automatic logic [15:0] next_count(input logic [15:0] c, input logic [15:0] r);
        next_count = (c == r) ? rtm_pkg::CNT_RELOAD : c + 16'h0001;
    endfunction

    // address of a per-timer register of timer t
    function automatic logic hit_tmr(input logic [7:0] a, input int t,
                                     input logic [3:0] ofs);
        logic [7:0] base;
        base = 8'(t) * rtm_pkg::TMR_STRIDE;
        hit_tmr = (a == (base | {4'h0, ofs}));
    endfunction

    // control word as software sees it
    function automatic logic [31:0] ctl_word(input rtm_pkg::rtm_state_t s,
                                             input int t);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[rtm_pkg::CTL_EN_BIT] = s.en[t];
        w[rtm_pkg::CTL_MODE_LSB +: 3] = s.mode[t];
        w[rtm_pkg::CTL_POL_BIT] = s.pol[t];
        w[rtm_pkg::CTL_OEN_BIT] = s.oen[t];
        w[rtm_pkg::CTL_PRESCALE_SELECT_LSB +: rtm_pkg::PRESCALE_SELECT_W] = s.prescale_select[t];
        ctl_word = w;
    endfunction

    // the external inputs come from another domain
    rtm_sync3 #(
        .W(rtm_pkg::NUM_TMR)
    ) u_in_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(tmr_in),
        .sync_out(in_lvl)
    );

    // one prescaler per timer, each fed from clk_sys
    for (genvar g = 0; g < rtm_pkg::NUM_TMR; g++) begin : g_tmr
        assign run[g] = s_r.en[g] && mode_runs(s_r.mode[g]);
        rtm_prescaler #(
            .W(rtm_pkg::PRESCALE_SELECT_W)
        ) u_prescale_select (
            .clk_sys(clk_sys),
            .rst(rst),
            .run(run[g]),
            .ratio_m1(s_r.prescale_select[g]),
            .tick(tick[g])
        );
    end

    // counting, matches, register writes and read capture
    always_comb begin
        logic [3:0] evt;
        logic [3:0] hit_ctl;
        logic [3:0] hit_cnt;
        logic [3:0] hit_cmp;
        logic [31:0] rd_word;
        logic [15:0] step;
        evt = 4'h0;
        step = 16'h0000;
        hit_ctl = 4'h0;
        hit_cnt = 4'h0;
        hit_cmp = 4'h0;
        rd_word = 32'h0000_0000;
        s_nxt = s_r;

        for (int t = 0; t < rtm_pkg::NUM_TMR; t++) begin
            hit_ctl[t] = hit_tmr(reg_addr, t, rtm_pkg::OFS_CTL);
            hit_cnt[t] = hit_tmr(reg_addr, t, rtm_pkg::OFS_CNT);
            hit_cmp[t] = hit_tmr(reg_addr, t, rtm_pkg::OFS_CMP);

            // the event fires on the step that lands on the reload value, so a
            // first pass lasts (reload - start) steps; in continuous mode the count
            // shows the reload value until the next step puts it back to 0001h,
            // which makes every later pass exactly reload steps long
            if (tick[t]) begin
                step = next_count(s_r.cnt[t], s_r.cmp[t]);
                s_nxt.cnt[t] = step;
                if (step == s_r.cmp[t]) begin
                    evt[t] = 1'b1;
                    if (s_r.oen[t]) begin
                        s_nxt.out[t] = ~s_r.out[t];
                    end
                    if (s_r.mode[t] == rtm_pkg::MODE_ONESHOT) begin
                        s_nxt.cnt[t] = rtm_pkg::CNT_RELOAD;
                        s_nxt.en[t] = 1'b0;
                    end
                end
            end

            // software writes win over the hardware step of the same cycle
            if (reg_wr && hit_ctl[t]) begin
                s_nxt.en[t] = reg_wdata[rtm_pkg::CTL_EN_BIT];
                s_nxt.mode[t] = reg_wdata[rtm_pkg::CTL_MODE_LSB +: 3];
                s_nxt.pol[t] = reg_wdata[rtm_pkg::CTL_POL_BIT];
                s_nxt.oen[t] = reg_wdata[rtm_pkg::CTL_OEN_BIT];
                s_nxt.prescale_select[t] = reg_wdata[rtm_pkg::CTL_PRESCALE_SELECT_LSB +: rtm_pkg::PRESCALE_SELECT_W];
                // enable going 0 -> 1 loads the initial output level
                if (!s_r.en[t] && reg_wdata[rtm_pkg::CTL_EN_BIT]) begin
                    s_nxt.out[t] = reg_wdata[rtm_pkg::CTL_POL_BIT];
                end
            end
            if (reg_wr && hit_cnt[t]) begin
                s_nxt.cnt[t] = reg_wdata[15:0];
            end
            if (reg_wr && hit_cmp[t]) begin
                s_nxt.cmp[t] = reg_wdata[15:0];
            end

            // read mux for the per-timer registers
            if (hit_ctl[t]) begin
                rd_word = ctl_word(s_r, t);
            end
            if (hit_cnt[t]) begin
                rd_word = {16'h0000, s_r.cnt[t]};
            end
            if (hit_cmp[t]) begin
                rd_word = {16'h0000, s_r.cmp[t]};
            end
        end

        // sticky status: write one clears, a new event in the same cycle wins
        if (reg_wr && reg_addr == rtm_pkg::OFS_INT_STAT) begin
            s_nxt.stat = s_r.stat & ~reg_wdata[3:0];
        end
        s_nxt.stat = s_nxt.stat | evt;

        if (reg_wr && reg_addr == rtm_pkg::OFS_INT_MASK) begin
            s_nxt.mask = reg_wdata[3:0];
        end

        // bank-wide reads; unmapped addresses read zero
        if (reg_addr == rtm_pkg::OFS_INT_STAT) begin
            rd_word = {28'h000_0000, s_r.stat};
        end
        if (reg_addr == rtm_pkg::OFS_INT_MASK) begin
            rd_word = {28'h000_0000, s_r.mask};
        end
        if (reg_addr == rtm_pkg::OFS_PIN_STAT) begin
            rd_word = 32'h0000_0000;
            rd_word[rtm_pkg::PIN_OUT_LSB +: 4] = s_r.out;
            rd_word[rtm_pkg::PIN_IN_LSB +: 4] = in_lvl;
        end

        // read data stand only in the cycle after the strobe
        s_nxt.rdata = reg_rd ? rd_word : 32'h0000_0000;
    end

    // single register stage for the whole bank
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r.en <= 4'h0;
            s_r.mode <= {4{rtm_pkg::MODE_ONESHOT}};
            s_r.pol <= 4'h0;
            s_r.oen <= 4'h0;
            s_r.prescale_select <= {4{rtm_pkg::PRESCALE_SELECT_RST}};
            s_r.cnt <= {4{rtm_pkg::CNT_RST}};
            s_r.cmp <= {4{rtm_pkg::CMP_RST}};
            s_r.out <= 4'h0;
            s_r.stat <= 4'h0;
            s_r.mask <= 4'h0;
            s_r.rdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops, interrupt is a level
    assign reg_rdata = s_r.rdata;
    assign tmr_out = s_r.out;
    assign tmr_out_oe = s_r.oen;
    assign irq = |(s_r.stat & s_r.mask);

endmodule // rtm_timer_bank

`default_nettype wire

// ### rtm_timer_bank_monitor.sv
// port-level checks of the reload timer bank
`default_nettype none

module rtm_timer_bank_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and interrupt
    input wire logic [3:0] tmr_in,
    input wire logic [3:0] tmr_out,
    input wire logic [3:0] tmr_out_oe,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // read data stands for one cycle only, so idle cycles must read zero
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    cnt_upper_a: assert property (reg_rd && reg_addr[3:0] == rtm_pkg::OFS_CNT
        && reg_addr[7:6] == 2'h0 |=> reg_rdata[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    // enable of the pin driver follows software only
    oe_write_only_a: assert property ($changed(tmr_out_oe) |-> $past(reg_wr))
        else $error("output enable moved without a write");
    pin_readback_a: assert property (reg_rd && reg_addr == rtm_pkg::OFS_PIN_STAT
        |=> reg_rdata[7:0] == {4'h0, $past(tmr_out)})
        else $error("pin status differs from output pins");
    // status is sticky: the line only drops after a clear or mask write
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a write");
    mask_off_a: assert property (reg_wr && reg_addr == rtm_pkg::OFS_INT_MASK
        && reg_wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all masked");
    mask_readback_a: assert property ((reg_wr && reg_addr == rtm_pkg::OFS_INT_MASK) ##2
        (reg_rd && reg_addr == rtm_pkg::OFS_INT_MASK)
        |=> reg_rdata == {28'h0, $past(reg_wdata[3:0], 3)})
        else $error("mask readback wrong");
endmodule // rtm_timer_bank_monitor

bind rtm_timer_bank rtm_timer_bank_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tmr_in(tmr_in), .tmr_out(tmr_out),
    .tmr_out_oe(tmr_out_oe), .irq(irq));

`default_nettype wire

// ### testbench.sv
// self-checking bench for the reload timer bank
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys;
    logic rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [3:0] tmr_in;
    logic [3:0] tmr_out;
    logic [3:0] tmr_out_oe;
    logic irq;
    int mismatches;
    int checked;
    localparam logic [7:0] A_STAT = rtm_pkg::OFS_INT_STAT;
    localparam logic [7:0] A_MASK = rtm_pkg::OFS_INT_MASK;

    rtm_timer_bank u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tmr_in(tmr_in), .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .irq(irq));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // address of a timer register
    function automatic logic [7:0] ra(input int t, input logic [3:0] ofs);
        ra = {t[3:0], ofs};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // counts clocks from the last taken write until irq rises
    task automatic wait_irq(input int exp);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 5000);
        chk(32'(n), 32'(exp));
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // longest test is a 4096-clock timeout; far below this limit
    initial begin
        #(40 * 20000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tmr_in = 4'hA;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, unmapped place, synced input pins
        rd(ra(0, rtm_pkg::OFS_CTL), 32'h0);
        rd(ra(1, rtm_pkg::OFS_CNT), 32'h1);
        rd(ra(3, rtm_pkg::OFS_CMP), 32'h0);
        rd(A_STAT, 32'h0);
        rd(8'hFC, 32'h0);
        rd(rtm_pkg::OFS_PIN_STAT, 32'h0000_0A00);
        // one-shot, ratio 1, count 1 to 3, polarity high, pin driven
        wr(ra(0, rtm_pkg::OFS_CTL), 32'h0);
        wr(ra(0, rtm_pkg::OFS_CNT), 32'h1);
        wr(ra(0, rtm_pkg::OFS_CMP), 32'h3);
        wr(A_MASK, 32'h1);
        rd(A_MASK, 32'h1);
        wr(ra(0, rtm_pkg::OFS_CTL), 32'h31);
        #1;
        chk({30'h0, tmr_out_oe[0], tmr_out[0]}, 32'h3);
        wait_irq(2);
        rd(ra(0, rtm_pkg::OFS_CTL), 32'h30);
        repeat (4) @(posedge clk_sys);
        rd(ra(0, rtm_pkg::OFS_CNT), 32'h1);
        rd(rtm_pkg::OFS_PIN_STAT, 32'h0000_0A00);
        rd(A_STAT, 32'h1);
        wr(A_STAT, 32'h1);
        #1;
        chk({31'h0, irq}, 32'h0);
        // continuous, ratio 3, start FFFE wraps through 0000 to reach 2
        wr(ra(1, rtm_pkg::OFS_CNT), 32'hFFFE);
        wr(ra(1, rtm_pkg::OFS_CMP), 32'h2);
        wr(A_MASK, 32'h2);
        wr(ra(1, rtm_pkg::OFS_CTL), 32'h0002_0003);
        wait_irq(12);
        wr(A_STAT, 32'h2);
        // later passes start at 0001: six clocks, two spent in the clear
        wait_irq(4);
        rd(ra(1, rtm_pkg::OFS_CTL), 32'h0002_0003);
        chk({31'h0, tmr_out_oe[1]}, 32'h0);
        wr(A_MASK, 32'h0);
        #1;
        chk({31'h0, irq}, 32'h0);
        rd(A_STAT, 32'h2);
        wr(ra(1, rtm_pkg::OFS_CTL), 32'h0);
        // largest prescale, one count from 0000 to 0001
        wr(ra(2, rtm_pkg::OFS_CNT), 32'h0);
        wr(ra(2, rtm_pkg::OFS_CMP), 32'h1);
        wr(A_MASK, 32'h4);
        wr(ra(2, rtm_pkg::OFS_CTL), 32'h0FFF_0001);
        wait_irq(4096);
        rd(ra(2, rtm_pkg::OFS_CNT), 32'h1);
        // an uncovered mode holds the count even with enable set
        wr(ra(3, rtm_pkg::OFS_CTL), 32'h5);
        repeat (3) @(posedge clk_sys);
        rd(ra(3, rtm_pkg::OFS_CNT), 32'h1);
        wr(ra(3, rtm_pkg::OFS_CTL), 32'h0);
        // slow change on the input pins reaches the pin status
        @(posedge clk_sys);
        tmr_in <= 4'h5;
        repeat (4) @(posedge clk_sys);
        rd(rtm_pkg::OFS_PIN_STAT, 32'h0000_0500);
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
